// ---- sncr_pkg.sv ----
/*
  sncr_pkg: register numbers, field positions, reset values and encodings
  for the switch node configuration register bank.
  Assumes nothing of its surroundings; imported by the bank module.
*/
package sncr_pkg;
  // register numbers, as carried in a configuration request
  localparam logic [7:0] REG_SWITCH_DESCRIPTION = 8'h01;
  localparam logic [7:0] REG_SWITCH_CONFIGURATION = 8'h04;
  localparam logic [7:0] REG_NODE_IDENTIFIER = 8'h05;
  localparam logic [7:0] REG_CLOCK_MULTIPLIER_SETTINGS = 8'h06;
  localparam logic [7:0] REG_SWITCH_CLOCK_DIVIDER = 8'h07;
  localparam logic [7:0] REG_REFERENCE_CLOCK_DIVIDER = 8'h08;
  localparam logic [7:0] REG_TEST_PORT_DEVICE_ID = 8'h09;
  localparam logic [7:0] REG_TEST_PORT_USER_CODE = 8'h0A;
  localparam logic [7:0] REG_ROUTING_DIRECTIONS_LOW = 8'h0C;
  localparam logic [7:0] REG_ROUTING_DIRECTIONS_HIGH = 8'h0D;
  localparam logic [7:0] REG_RESERVED_CONTROL_A = 8'h10;
  localparam logic [7:0] REG_RESERVED_CONTROL_B = 8'h11;
  localparam logic [7:0] REG_DEBUG_EVENT_SOURCE = 8'h1F;

  // switch configuration fields
  localparam int CFG_CTRL_LOCK_BIT = 31;
  localparam int CFG_MULT_LOCK_BIT = 8;
  localparam int CFG_HEADER_BIT = 0;

  // clock multiplier settings fields
  localparam int MUL_NO_RESET_BIT = 31;
  localparam int MUL_NO_WAIT_BIT = 30;
  localparam int MUL_BYPASS_BIT = 29;
  localparam int MUL_TAP_BOOT_BIT = 28;
  localparam int MUL_OUT_DIV_HI = 25;
  localparam int MUL_OUT_DIV_LO = 23;
  localparam int MUL_FEEDBACK_HI = 20;
  localparam int MUL_FEEDBACK_LO = 8;
  localparam int MUL_IN_DIV_HI = 6;
  localparam int MUL_IN_DIV_LO = 0;
  // writable bits of the multiplier settings word
  localparam logic [31:0] MUL_WRITE_MASK = 32'hF39FFF7F;

  // description fields
  localparam int DESC_LINKS_LO = 16;
  localparam int DESC_CORES_SW_LO = 8;
  localparam int DESC_CORES_DEV_LO = 0;
  localparam int USER_CODE_LO = 18;

  // reset values
  localparam logic [31:0] MUL_RESET = 32'h00000000;
  localparam logic [15:0] SWITCH_DIV_RESET = 16'h0000;
  localparam logic [15:0] REF_DIV_RESET = 16'h0003;
  localparam logic [15:0] NODE_ID_RESET = 16'h0000;
  localparam logic [31:0] DIRS_RESET = 32'h00000000;

  // width of a reserved-control register and of the debug source register
  localparam int RSV_BITS = 2;
  localparam int DBG_BITS = 5;
  localparam logic [31:0] DBG_WRITE_MASK = 32'h00000013;
  localparam int DIR_BITS = 4;
  localparam int ID_BITS = 16;

  // request handling states
  typedef enum logic [2:0] {
    SNCR_IDLE = 3'b001,
    SNCR_ANSWER = 3'b010,
    SNCR_RESET_TILE = 3'b100
  } sncr_state_e;

  // length of the tile reset pulse, in mclk cycles
  localparam logic [3:0] TILE_RESET_CYCLES = 4'h4;
endpackage

// ---- sncr_bank.sv ----
/*
  sncr_bank: node configuration register bank of the packet-switch node,
  with the routing decision that its direction tables steer.
  Assumes requests arrive from switch logic on mclk (no synchroniser) and
  that the requester holds a request until it sees cfg_done.
*/
// Function
// - description register reports link count, switch cores and device cores read-only.
// - control lock bit 31 set refuses writes to switch control registers.
// - multiplier lock bit 8 set blocks writes to multiplier settings.
// - configuration bit 0 picks header size: 0 two-byte, 1 one-byte.
// - writable 16-bit node identifier, reset zero, upper bits read zero.
// - accepted multiplier settings write resets the tile unless no-reset bit set.
// - multiplier write with bit 31 set skips the tile reset.
// - multiplier bit 30 set means do not wait for relock.
// - multiplier bit 29 set bypasses the clock multiplier.
// - multiplier bit 28 set forces boot through the test access port.
// - multiplier bits 25:23 hold output divider, 0 to 7.
// - multiplier bits 20:8 hold feedback ratio.
// - multiplier bits 6:0 hold input divider value.
// - switch clock divider is writable 16 bits, reset 0.
// - reference clock divider is writable 16 bits, reset 3.
// - user code register shows stored user code and fixable id read-only.
// - low table holds eight 4-bit directions for dimensions 0 to 7.
// - high table holds eight 4-bit directions for dimensions 8 to 15.
// - packet goes the direction of the highest mismatching identifier bit.
// - debug source bits 0 and 1 name core zero or one; writable.
// - registers are reached only by numbered configuration reads and writes; debug source is also loaded by core debug events.
`timescale 1ns/1ns
module sncr_bank
  import sncr_pkg::*;
#(
  parameter logic [7:0] NUM_LINKS = 8'h08,
  parameter logic [7:0] NUM_SWITCH_CORES = 8'h02,
  parameter logic [7:0] NUM_DEVICE_CORES = 8'h02,
  parameter logic [31:0] DEVICE_ID_CODE = 32'h00000001, // arbitrary value
  parameter logic [13:0] USER_CODE_OTP = 14'h0000, // arbitrary value
  parameter logic [17:0] FIXABLE_ID = 18'h00001 // arbitrary value
) (
  input wire logic mclk,
  input wire logic rst_n,
  input wire logic cfg_req,
  input wire logic cfg_write,
  input wire logic [7:0] cfg_reg_num,
  input wire logic [31:0] cfg_wdata,
  output logic cfg_done,
  output logic cfg_refused,
  output logic [31:0] cfg_rdata,
  input wire logic dbg_event_core_zero,
  input wire logic dbg_event_core_one,
  input wire logic [15:0] pkt_dest_id,
  output logic pkt_local,
  output logic [3:0] pkt_direction,
  output logic one_byte_header,
  output logic [2:0] mul_output_divider,
  output logic [12:0] mul_feedback_ratio,
  output logic [6:0] mul_input_divider,
  output logic mul_bypass,
  output logic mul_no_relock_wait,
  output logic boot_from_test_port,
  output logic [15:0] switch_clock_ratio,
  output logic [15:0] reference_clock_ratio,
  output logic tile_reset
);
  import sncr_pkg::*;

  // clock and reset for the checks that name neither
  default clocking @(posedge mclk);
  endclocking
  default disable iff (!rst_n);

  sncr_state_e state;
  sncr_state_e next_state;
  logic [31:0] cfg_word;
  logic [15:0] node_id;
  logic [31:0] mul_word;
  logic [15:0] sw_div;
  logic [15:0] ref_div;
  logic [31:0] dirs_low;
  logic [31:0] dirs_high;
  logic [RSV_BITS-1:0] rsv_a;
  logic [RSV_BITS-1:0] rsv_b;
  logic [DBG_BITS-1:0] dbg_src;
  logic [3:0] reset_count;
  logic [31:0] next_rdata;

  // register number decode
  wire take = (state == SNCR_IDLE) && cfg_req;
  wire hit_desc = (cfg_reg_num == REG_SWITCH_DESCRIPTION);
  wire hit_cfg = (cfg_reg_num == REG_SWITCH_CONFIGURATION);
  wire hit_id = (cfg_reg_num == REG_NODE_IDENTIFIER);
  wire hit_mul = (cfg_reg_num == REG_CLOCK_MULTIPLIER_SETTINGS);
  wire hit_swd = (cfg_reg_num == REG_SWITCH_CLOCK_DIVIDER);
  wire hit_ref = (cfg_reg_num == REG_REFERENCE_CLOCK_DIVIDER);
  wire hit_dl = (cfg_reg_num == REG_ROUTING_DIRECTIONS_LOW);
  wire hit_dh = (cfg_reg_num == REG_ROUTING_DIRECTIONS_HIGH);
  wire hit_ra = (cfg_reg_num == REG_RESERVED_CONTROL_A);
  wire hit_rb = (cfg_reg_num == REG_RESERVED_CONTROL_B);
  wire hit_dbg = (cfg_reg_num == REG_DEBUG_EVENT_SOURCE);

  // write locks: the lock bit itself stays writable so software can unlock
  wire ctrl_locked = cfg_word[CFG_CTRL_LOCK_BIT];
  wire mul_locked = cfg_word[CFG_MULT_LOCK_BIT] | ctrl_locked;
  wire wr = take && cfg_write;
  wire lock_hit = ctrl_locked && (hit_id || hit_swd || hit_ref || hit_dl || hit_dh || hit_ra || hit_rb || hit_dbg);
  wire refuse = wr && ((hit_mul && mul_locked) || lock_hit);
  wire wr_ok = wr && !refuse;
  wire mul_write = wr_ok && hit_mul;
  wire start_tile_reset = mul_write && !cfg_wdata[MUL_NO_RESET_BIT];

  // read data multiplexer
  always_comb begin
    next_rdata = 32'h00000000;
    case (cfg_reg_num)
      REG_SWITCH_DESCRIPTION: next_rdata = {8'h00, NUM_LINKS, NUM_SWITCH_CORES, NUM_DEVICE_CORES};
      REG_SWITCH_CONFIGURATION: next_rdata = cfg_word;
      REG_NODE_IDENTIFIER: next_rdata = {16'h0000, node_id};
      REG_CLOCK_MULTIPLIER_SETTINGS: next_rdata = mul_word;
      REG_SWITCH_CLOCK_DIVIDER: next_rdata = {16'h0000, sw_div};
      REG_REFERENCE_CLOCK_DIVIDER: next_rdata = {16'h0000, ref_div};
      REG_TEST_PORT_DEVICE_ID: next_rdata = DEVICE_ID_CODE;
      REG_TEST_PORT_USER_CODE: next_rdata = {USER_CODE_OTP, FIXABLE_ID};
      REG_ROUTING_DIRECTIONS_LOW: next_rdata = dirs_low;
      REG_ROUTING_DIRECTIONS_HIGH: next_rdata = dirs_high;
      REG_RESERVED_CONTROL_A: next_rdata = {30'h00000000, rsv_a};
      REG_RESERVED_CONTROL_B: next_rdata = {30'h00000000, rsv_b};
      REG_DEBUG_EVENT_SOURCE: next_rdata = {27'h0000000, dbg_src};
      default: next_rdata = 32'h00000000;
    endcase
  end

  // request sequencer: one request, one answer; tile reset follows a multiplier write with bit 31 clear
  always_comb begin
    case (state)
      SNCR_IDLE: next_state = take ? SNCR_ANSWER : SNCR_IDLE;
      SNCR_ANSWER: next_state = (reset_count != 4'h0) ? SNCR_RESET_TILE : SNCR_IDLE;
      SNCR_RESET_TILE: next_state = (reset_count == 4'h1) ? SNCR_IDLE : SNCR_RESET_TILE;
      default: next_state = SNCR_IDLE;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      state <= SNCR_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // answer word and refusal flag, captured when the request is taken
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_rdata <= 32'h00000000;
      cfg_refused <= 1'b0;
    end else if (take) begin
      cfg_rdata <= cfg_write ? 32'h00000000 : next_rdata;
      cfg_refused <= refuse;
    end
  end

  assign cfg_done = (state == SNCR_ANSWER);

  // tile reset pulse counter
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      reset_count <= 4'h0;
    end else if (start_tile_reset) begin
      reset_count <= TILE_RESET_CYCLES;
    end else if (state == SNCR_RESET_TILE) begin
      reset_count <= reset_count - 4'h1;
    end
  end

  assign tile_reset = (state == SNCR_RESET_TILE);

  // configuration word: only bits 31, 8 and 0 are storage
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      cfg_word <= 32'h00000000;
    end else if (wr_ok && hit_cfg) begin
      cfg_word <= cfg_wdata & 32'h80000101;
    end
  end

  // control registers guarded by the control lock
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      node_id <= NODE_ID_RESET;
      sw_div <= SWITCH_DIV_RESET;
      ref_div <= REF_DIV_RESET;
      dirs_low <= DIRS_RESET;
      dirs_high <= DIRS_RESET;
      rsv_a <= 2'h0;
      rsv_b <= 2'h0;
    end else begin
      if (wr_ok && hit_id) node_id <= cfg_wdata[15:0];
      if (wr_ok && hit_swd) sw_div <= cfg_wdata[15:0];
      if (wr_ok && hit_ref) ref_div <= cfg_wdata[15:0];
      if (wr_ok && hit_dl) dirs_low <= cfg_wdata;
      if (wr_ok && hit_dh) dirs_high <= cfg_wdata;
      if (wr_ok && hit_ra) rsv_a <= cfg_wdata[1:0];
      if (wr_ok && hit_rb) rsv_b <= cfg_wdata[1:0];
    end
  end

  // multiplier settings; reserved bits never stored
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      mul_word <= MUL_RESET;
    end else if (mul_write) begin
      mul_word <= cfg_wdata & MUL_WRITE_MASK;
    end
  end

  // debug source: a new event wins over a software write in the same cycle
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      dbg_src <= 5'h00;
    end else if (dbg_event_core_zero || dbg_event_core_one) begin
      dbg_src <= {dbg_src[4], 2'b00, dbg_event_core_one, dbg_event_core_zero};
    end else if (wr_ok && hit_dbg) begin
      dbg_src <= cfg_wdata[4:0] & DBG_WRITE_MASK[4:0];
    end
  end

  assign one_byte_header = cfg_word[CFG_HEADER_BIT];
  assign mul_output_divider = mul_word[MUL_OUT_DIV_HI:MUL_OUT_DIV_LO];
  assign mul_feedback_ratio = mul_word[MUL_FEEDBACK_HI:MUL_FEEDBACK_LO];
  assign mul_input_divider = mul_word[MUL_IN_DIV_HI:MUL_IN_DIV_LO];
  assign mul_bypass = mul_word[MUL_BYPASS_BIT];
  assign mul_no_relock_wait = mul_word[MUL_NO_WAIT_BIT];
  assign boot_from_test_port = mul_word[MUL_TAP_BOOT_BIT];
  assign switch_clock_ratio = sw_div;
  assign reference_clock_ratio = ref_div;

  // routing: highest mismatching bit indexes the joined direction tables
  function automatic logic [4:0] top_mismatch(input logic [15:0] diff);
    logic [4:0] idx;
    idx = 5'h10;
    for (int i = 0; i < ID_BITS; i++) begin
      if (diff[i]) idx = 5'(i);
    end
    return idx;
  endfunction

  wire [15:0] id_diff = pkt_dest_id ^ node_id;
  wire [4:0] dim = top_mismatch(id_diff);
  wire [63:0] dir_table = {dirs_high, dirs_low};
  wire [3:0] dir_pick = dir_table[{dim[3:0], 2'b00} +: DIR_BITS];

  // registered decision; matched packets stay local and take no direction
  always_ff @(posedge mclk) begin
    if (!rst_n) begin
      pkt_local <= 1'b0;
      pkt_direction <= 4'h0;
    end else begin
      pkt_local <= (id_diff == 16'h0000);
      pkt_direction <= (id_diff == 16'h0000) ? 4'h0 : dir_pick;
    end
  end

  a_lock_refuse: assert property (@(posedge mclk) disable iff (!rst_n)
    (take && cfg_write && hit_mul && mul_locked) |=> (cfg_refused && $stable(mul_word)))
    else $error("locked multiplier write changed settings");
  a_ctrl_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    (take && cfg_write && hit_id && ctrl_locked) |=> (cfg_refused && $stable(node_id)))
    else $error("locked node id write accepted");
  a_no_reset_lock: assert property (@(posedge mclk) disable iff (!rst_n)
    (take && cfg_write && hit_mul && mul_locked && state == SNCR_IDLE) |-> ##2 !tile_reset)
    else $error("locked write reset the tile");
  a_tile_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (mul_write && !cfg_wdata[MUL_NO_RESET_BIT]) |-> ##2 tile_reset[*4] ##1 !tile_reset)
    else $error("tile reset pulse wrong");
  a_skip_reset: assert property (@(posedge mclk) disable iff (!rst_n)
    (mul_write && cfg_wdata[MUL_NO_RESET_BIT]) |-> ##2 !tile_reset)
    else $error("no-reset write reset the tile");
  a_id_write: assert property (@(posedge mclk) disable iff (!rst_n)
    (wr_ok && hit_id) |=> (node_id == $past(cfg_wdata[15:0])))
    else $error("node id not stored");
  a_desc_read: assert property (@(posedge mclk) disable iff (!rst_n)
    (take && !cfg_write && cfg_reg_num == REG_SWITCH_DESCRIPTION) |=> cfg_done && cfg_rdata[23:16] == NUM_LINKS)
    else $error("description read wrong");
  a_route_local: assert property (@(posedge mclk) disable iff (!rst_n)
    (pkt_dest_id == node_id) |=> (pkt_local && pkt_direction == 4'h0))
    else $error("local packet routed");
  a_route_top: assert property (@(posedge mclk) disable iff (!rst_n)
    (id_diff[15]) |=> (pkt_direction == $past(dirs_high[31:28])))
    else $error("top mismatch direction wrong");
  a_answer_once: assert property (@(posedge mclk) disable iff (!rst_n)
    take |=> cfg_done ##1 !cfg_done)
    else $error("answer not single cycle");
  a_dbg_core_one: assert property (@(posedge mclk) disable iff (!rst_n)
    (dbg_event_core_one && !dbg_event_core_zero) |=> (dbg_src[1:0] == 2'b10))
    else $error("debug source not recorded");
  a_ref_reset: assert property (@(posedge mclk) $rose(rst_n) |-> reference_clock_ratio == REF_DIV_RESET)
    else $error("reference divider reset value wrong");

  // stored fields follow accepted writes one cycle later; reserved bits stay zero
  a_cfg_store: assert property (
    (wr_ok && hit_cfg) |=> (cfg_word == $past({cfg_wdata[31], 22'h0, cfg_wdata[8], 7'h0, cfg_wdata[0]})))
    else $error("configuration word not stored");
  a_out_div: assert property (
    mul_write |=> (mul_output_divider == $past(cfg_wdata[MUL_OUT_DIV_HI:MUL_OUT_DIV_LO])))
    else $error("output divider not stored");
  a_feedback_ratio: assert property (
    mul_write |=> (mul_feedback_ratio == $past(cfg_wdata[MUL_FEEDBACK_HI:MUL_FEEDBACK_LO])))
    else $error("feedback ratio not stored");
  a_in_div: assert property (
    mul_write |=> (mul_input_divider == $past(cfg_wdata[MUL_IN_DIV_HI:MUL_IN_DIV_LO])))
    else $error("input divider not stored");
  a_bypass_bit: assert property (
    mul_write |=> (mul_bypass == $past(cfg_wdata[MUL_BYPASS_BIT])))
    else $error("bypass bit not stored");
  a_relock_skip: assert property (
    mul_write |=> (mul_no_relock_wait == $past(cfg_wdata[MUL_NO_WAIT_BIT])))
    else $error("relock wait bit not stored");
  a_tap_boot: assert property (
    mul_write |=> (boot_from_test_port == $past(cfg_wdata[MUL_TAP_BOOT_BIT])))
    else $error("test port boot bit not stored");
  a_mul_reserved: assert property (
    mul_write |=> (mul_word[27:26] == 2'b00 && mul_word[22:21] == 2'b00 && !mul_word[7]))
    else $error("reserved multiplier bits stored");
  a_sw_div: assert property (
    (wr_ok && hit_swd) |=> (switch_clock_ratio == $past(cfg_wdata[15:0])))
    else $error("switch divider not stored");
  a_ref_div: assert property (
    (wr_ok && hit_ref) |=> (reference_clock_ratio == $past(cfg_wdata[15:0])))
    else $error("reference divider not stored");
  a_sw_div_reset: assert property (
    $rose(rst_n) |-> (switch_clock_ratio == SWITCH_DIV_RESET))
    else $error("switch divider reset value wrong");
  a_user_code: assert property (
    (take && !cfg_write && cfg_reg_num == REG_TEST_PORT_USER_CODE) |=> (cfg_rdata == {USER_CODE_OTP, FIXABLE_ID}))
    else $error("user code read wrong");
  a_desc_cores: assert property (
    (take && !cfg_write && hit_desc) |=> (cfg_rdata[31:24] == 8'h00 && cfg_rdata[15:0] == {NUM_SWITCH_CORES, NUM_DEVICE_CORES}))
    else $error("description core counts wrong");
  a_low_store: assert property (
    (wr_ok && hit_dl) |=> (dirs_low == $past(cfg_wdata)))
    else $error("low direction table not stored");
  a_high_store: assert property (
    (wr_ok && hit_dh) |=> (dirs_high == $past(cfg_wdata)))
    else $error("high direction table not stored");
  a_route_seven: assert property (
    (id_diff[15:7] == 9'h001) |=> (pkt_direction == $past(dirs_low[31:28])))
    else $error("dimension seven direction wrong");
  a_route_eight: assert property (
    (id_diff[15:8] == 8'h01) |=> (pkt_direction == $past(dirs_high[3:0])))
    else $error("dimension eight direction wrong");
  a_route_zero: assert property (
    (id_diff == 16'h0001) |=> (pkt_direction == $past(dirs_low[3:0])))
    else $error("dimension zero direction wrong");
  a_dbg_core_zero: assert property (
    (dbg_event_core_zero && !dbg_event_core_one) |=> (dbg_src[1:0] == 2'b01))
    else $error("core zero event not recorded");
  a_dbg_write: assert property (
    (wr_ok && hit_dbg && !dbg_event_core_zero && !dbg_event_core_one) |=>
      (dbg_src == $past({cfg_wdata[4], 2'b00, cfg_wdata[1:0]})))
    else $error("debug source write not stored");
  a_dirs_lock: assert property (
    (take && cfg_write && hit_dl && ctrl_locked) |=> (cfg_refused && $stable(dirs_low)))
    else $error("locked direction write accepted");
  a_reset_wait: assert property (
    (tile_reset && cfg_req) |=> !cfg_done)
    else $error("request answered during tile reset");
  a_read_no_refuse: assert property (
    (take && !cfg_write) |=> !cfg_refused)
    else $error("read marked refused");

  c_mul_write: cover property (@(posedge mclk) disable iff (!rst_n) mul_write ##2 tile_reset);
  c_refused: cover property (@(posedge mclk) disable iff (!rst_n) refuse);
  c_route_high: cover property (@(posedge mclk) disable iff (!rst_n) id_diff[15] && !pkt_local);
  c_read_back: cover property (@(posedge mclk) disable iff (!rst_n) take && !cfg_write && hit_dl);
  c_skip_reset: cover property (mul_write && cfg_wdata[MUL_NO_RESET_BIT]);
endmodule // sncr_bank

// ---- sncr_req_model.sv ----
/*
  sncr_req_model: configuration requester that faces the register bank.
  Assumes the bench supplies mclk; lines change on the falling edge.
*/
`timescale 1ns/1ns
module sncr_req_model (
  input wire logic mclk,
  input wire logic cfg_done,
  output logic cfg_req,
  output logic cfg_write,
  output logic [7:0] cfg_reg_num,
  output logic [31:0] cfg_wdata
);
  // idle lines at time zero
  initial begin
    cfg_req = 1'b0;
    cfg_write = 1'b0;
    cfg_reg_num = 8'h00;
    cfg_wdata = 32'h00000000;
  end

  // one numbered request, held until the bank answers or 50 more falling edges pass
  task automatic xfer(input logic w, input logic [7:0] n, input logic [31:0] d);
    int k;
    @(negedge mclk);
    cfg_req = 1'b1;
    cfg_write = w;
    cfg_reg_num = n;
    cfg_wdata = d;
    k = 0;
    while (cfg_done !== 1'b1 && k < 50) begin
      @(negedge mclk);
      k++;
    end
    // drop now or the request is taken twice; released lines show junk
    cfg_req = 1'b0;
    cfg_write = ~w;
    cfg_reg_num = ~n;
    cfg_wdata = ~d;
  endtask
endmodule // sncr_req_model

// ---- tb_top.sv ----
/*
  tb_top: self-checking bench for the node configuration register bank.
  Assumes sncr_pkg and sncr_bank are compiled first.
*/
`timescale 1ns/1ns
module tb_top;
  import sncr_pkg::*;
  localparam logic [7:0] LNK = 8'h05;
  localparam logic [7:0] SWC = 8'h03;
  localparam logic [7:0] DVC = 8'h04;
  localparam logic [13:0] UC = 14'h01A5; // arbitrary value
  localparam logic [17:0] FX = 18'h02B3C; // arbitrary value
  localparam logic [31:0] DID = 32'h000005C3; // arbitrary value
  localparam logic [31:0] DESC = {8'h00, LNK, SWC, DVC};
  logic mclk, rst_n, dbg0, dbg1, done, refused, req, wr, lhit, hdr, byp, nowait, tap, trst;
  logic [7:0] num;
  logic [15:0] dest, nid, swr, rfr;
  logic [31:0] rdata, wdata, v, lo, hi;
  logic [3:0] dir;
  logic [2:0] odiv;
  logic [12:0] fb;
  logic [6:0] idiv;
  logic [32:0] q[$];
  logic [32:0] e;
  logic [31:0] vals [7];
  logic [7:0] rn [11] = '{8'h01, 8'h04, 8'h05, 8'h06, 8'h07, 8'h08, 8'h09, 8'h0A, 8'h0C, 8'h0D, 8'h02};
  logic [31:0] rx [11] = '{DESC, 0, 0, MUL_RESET, 0, {16'h0, REF_DIV_RESET}, DID, {UC, FX}, DIRS_RESET, DIRS_RESET, 0};
  logic [7:0] wn [7] = '{8'h05, 8'h07, 8'h08, 8'h0C, 8'h0D, 8'h10, 8'h11};
  logic [31:0] wm [7] = '{32'h0000FFFF, 32'h0000FFFF, 32'h0000FFFF, 32'hFFFFFFFF, 32'hFFFFFFFF, 32'h3, 32'h3};
  int mismatches, checks_done, cycles, hi_cnt, pulses, exp_pulses;
  integer seed = 70222;

  sncr_bank #(.NUM_LINKS(LNK), .NUM_SWITCH_CORES(SWC), .NUM_DEVICE_CORES(DVC), .USER_CODE_OTP(UC),
    .FIXABLE_ID(FX), .DEVICE_ID_CODE(DID)) i_dut (.mclk(mclk), .rst_n(rst_n), .cfg_req(req), .cfg_write(wr),
    .cfg_reg_num(num), .cfg_wdata(wdata), .cfg_done(done), .cfg_refused(refused), .cfg_rdata(rdata),
    .dbg_event_core_zero(dbg0), .dbg_event_core_one(dbg1), .pkt_dest_id(dest), .pkt_local(lhit),
    .pkt_direction(dir), .one_byte_header(hdr), .mul_output_divider(odiv), .mul_feedback_ratio(fb),
    .mul_input_divider(idiv), .mul_bypass(byp), .mul_no_relock_wait(nowait),
    .boot_from_test_port(tap), .switch_clock_ratio(swr), .reference_clock_ratio(rfr), .tile_reset(trst));

  sncr_req_model i_req (.mclk(mclk), .cfg_done(done), .cfg_req(req), .cfg_write(wr),
    .cfg_reg_num(num), .cfg_wdata(wdata));

  task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      mismatches++;
      $display("Error %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // note the expected answer, then hand the request to the requester
  task automatic acc(input logic w, input logic [7:0] n, input logic [31:0] d, input logic [31:0] x,
    input logic rf);
    q.push_back({rf, x});
    i_req.xfer(w, n, d);
  endtask

  // highest mismatching bit picks the field; a full match leaves 0
  function automatic logic [3:0] route(input logic [15:0] d);
    logic [63:0] t;
    t = {hi, lo};
    route = 4'h0;
    for (int k = 0; k < 16; k++) if (d[k] !== nid[k]) route = t[4*k +: 4];
  endfunction

  initial begin
    mclk = 1'b0;
    forever #10 mclk = ~mclk;
  end

  // answer watcher, tile reset pulse length and hang limit
  always @(posedge mclk) begin
    cycles++;
    if (done === 1'b1) begin
      e = q.size() > 0 ? q.pop_front() : 33'h1DEADBEEF;
      check("cfg_rdata", rdata, e[31:0]);
      check("cfg_refused", {31'h0, refused}, {31'h0, e[32]});
    end
    if (trst === 1'b1) hi_cnt++;
    else if (hi_cnt != 0) begin
      check("tile_reset cycles", hi_cnt, {28'h0, TILE_RESET_CYCLES});
      hi_cnt = 0;
      pulses++;
    end
    if (cycles == 20000) begin
      mismatches++;
      end_of_test();
    end
  end

  initial begin
    rst_n = 1'b0;
    dbg0 = 1'b0;
    dbg1 = 1'b0;
    dest = 16'h0000;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    check("reference_clock_ratio", {16'h0, rfr}, {16'h0, REF_DIV_RESET});
    // reset values, read-only words and an unmapped number
    for (int i = 0; i < 11; i++) acc(1'b0, rn[i], 32'h0, rx[i], 1'b0);
    // random data through the node id, divider, direction and reserved-control words, reserved bits read zero
    for (int i = 0; i < 7; i++) begin
      vals[i] = $random(seed);
      acc(1'b1, wn[i], vals[i], 32'h0, 1'b0);
      acc(1'b0, wn[i], 32'h0, vals[i] & wm[i], 1'b0);
    end
    check("clock ratios", {swr, rfr}, {vals[1][15:0], vals[2][15:0]});
    nid = vals[0][15:0];
    lo = vals[3];
    hi = vals[4];
    acc(1'b1, 8'h01, 32'hFFFFFFFF, 32'h0, 1'b0);
    acc(1'b0, 8'h01, 32'h0, DESC, 1'b0);
    // routing: full match, top and bottom dimensions, dimensions 7 and 8, then random
    for (int i = 0; i < 24; i++) begin
      @(negedge mclk);
      dest = i == 0 ? nid : i == 1 ? nid ^ 16'h8000 : i == 2 ? nid ^ 16'h0001 :
        i == 3 ? nid ^ 16'h0080 : i == 4 ? nid ^ 16'h0100 : 16'($random(seed));
      @(negedge mclk);
      check("pkt_direction", {28'h0, dir}, {28'h0, route(dest)});
      check("pkt_local", {31'h0, lhit}, {31'h0, dest === nid});
    end
    acc(1'b1, 8'h04, 32'h1, 32'h0, 1'b0);
    check("one_byte_header", {31'h0, hdr}, 32'h1);
    // resetting multiplier write, then one that skips the reset
    v = $random(seed) & 32'h7FFFFFFF;
    exp_pulses++;
    acc(1'b1, 8'h06, v, 32'h0, 1'b0);
    check("multiplier fields", {6'h0, byp, nowait, tap, odiv, fb, idiv},
      {6'h0, v[29], v[30], v[28], v[25:23], v[20:8], v[6:0]});
    acc(1'b0, 8'h06, 32'h0, v & MUL_WRITE_MASK, 1'b0);
    v = $random(seed) | 32'h80000000;
    acc(1'b1, 8'h06, v, 32'h0, 1'b0);
    acc(1'b0, 8'h06, 32'h0, v & MUL_WRITE_MASK, 1'b0);
    // multiplier lock alone, then every lock
    acc(1'b1, 8'h04, 32'h00000100, 32'h0, 1'b0);
    acc(1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h04, 32'hFFFFFFFF, 32'h0, 1'b0);
    acc(1'b0, 8'h04, 32'h0, 32'h80000101, 1'b0);
    for (int i = 0; i < 7; i++) acc(1'b1, wn[i], 32'h0, 32'h0, 1'b1);
    acc(1'b1, 8'h06, 32'h0, 32'h0, 1'b1);
    acc(1'b0, 8'h06, 32'h0, v & MUL_WRITE_MASK, 1'b0);
    acc(1'b0, 8'h05, 32'h0, {16'h0, nid}, 1'b0);
    acc(1'b1, 8'h04, 32'h0, 32'h0, 1'b0);
    acc(1'b1, 8'h05, 32'h0, 32'h0, 1'b0);
    acc(1'b0, 8'h05, 32'h0, 32'h0, 1'b0);
    // debug events from each core, then a plain write
    @(negedge mclk) dbg0 = 1'b1;
    @(negedge mclk) dbg0 = 1'b0;
    acc(1'b0, 8'h1F, 32'h0, 32'h1, 1'b0);
    @(negedge mclk) dbg1 = 1'b1;
    @(negedge mclk) dbg1 = 1'b0;
    acc(1'b0, 8'h1F, 32'h0, 32'h2, 1'b0);
    acc(1'b1, 8'h1F, 32'h00000011, 32'h0, 1'b0);
    acc(1'b0, 8'h1F, 32'h0, 32'h00000011, 1'b0);
    // mid-run reset brings the written registers back to their reset values
    @(negedge mclk) rst_n = 1'b0;
    repeat (3) @(negedge mclk);
    rst_n = 1'b1;
    check("reference_clock_ratio", {16'h0, rfr}, {16'h0, REF_DIV_RESET});
    acc(1'b0, 8'h08, 32'h0, {16'h0, REF_DIV_RESET}, 1'b0);
    acc(1'b0, 8'h0C, 32'h0, DIRS_RESET, 1'b0);
    acc(1'b0, 8'h1F, 32'h0, 32'h0, 1'b0);
    repeat (8) @(negedge mclk);
    check("tile reset pulses", pulses, exp_pulses);
    // a request the requester gave up on leaves its note behind
    check("answers pending", q.size(), 0);
    end_of_test();
  end
endmodule // tb_top
